// *** error_source_model.sv ***
// Model of the pipeline and memory error sources feeding the barrier unit
`timescale 1ns/1ps
`default_nettype none

module error_source_model (
   input  wire logic                        ref_clk,
   input  wire logic                        reset,
   input  wire logic                        go,
   input  wire logic [3:0]                  go_len,
   input  wire error_sync_pkg::err_report_t go_rep,
   output logic                             err_valid,
   output error_sync_pkg::err_report_t      err_report,
   output logic                             err_inflight
);
   logic [3:0]                  left;
   error_sync_pkg::err_report_t held;

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         left <= 4'h0;
      end else if (go) begin
         left <= go_len;
      end else if (left != 4'h0) begin
         left <= left - 4'h1;
      end
   end
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         held <= '0;
      end else if (go) begin
         held <= go_rep;
      end
   end
   // Older access in flight; its report lands on the last in-flight cycle
   assign err_inflight = (left != 4'h0);
   assign err_valid = (left == 4'h1);
   // Garbage outside a report so a stale value is never mistaken for one
   assign err_report = err_valid ? held : ~held;
endmodule

`default_nettype wire

// *** error_sync_barrier_unit.sv ***
// Error synchronization barrier unit: explicit and implicit barriers
//
// Notes on behaviour
// - Every consumed, contained unrecoverable error is synchronized by barrier events.
// - Synchronous aborts and recovery interrupts are untouched by barrier events.
// - Barrier instruction syncs errors; may record then clear masked pending error.
// - Deferred register kernel-or-above; routed nonsecure kernel access hits virtual copy.
// - Setting deferred flag for physical error clears its pending state.
// - Setting virtual deferred flag clears the virtual error pending bit.
// - All earlier unrecoverable errors have pended before event completes.
// - Unmasked pending physical error is taken, return address is barrier's address.
// - Masked at explicit barrier: clear pending, store syndrome, set flag.
// - Errors after the barrier are taken later, never deferred by it.
// - Taken contained errors report unrecoverable in syndrome; deferred ones in deferred register.
// - Unconsumed errors taken or deferred at a barrier are reported precise.
// - Uncontainable errors may be taken or deferred; otherwise stay pending.
// - User/kernel barrier syncs virtual error when hyp enabled, routed, not trap-general.
// - Unmasked pending virtual error is taken before barrier completes; the unit leaves it pending when a physical error is taken at the same barrier.
// - Masked virtual error: clear pending, copy virtual syndrome, set virtual flag.
// - Entry above user level with implicit bit: unmasked error taken first, masked stays.
// - Before return instructions: unmasked error taken at return address, masked stays.
// - Implicit barrier leaves both deferred registers unchanged.
// - Error taken after exception through implicit barrier sets implicit indicator.
// - Error ahead of exception: indicator zero, error type states restartability.
// - Double-fault extension with nonmaskable abort forces monitor implicit bit on.
`timescale 1ns/1ps
`default_nettype none

module error_sync_barrier_unit (
   input  wire logic                                  ref_clk,
   input  wire logic                                  reset,
   // Wishbone classic slave
   input  wire logic                                  wb_cyc_i,
   input  wire logic                                  wb_stb_i,
   input  wire logic                                  wb_we_i,
   input  wire logic [7:0]                            wb_adr_i,
   input  wire logic [3:0]                            wb_sel_i,
   input  wire logic [31:0]                           wb_dat_i,
   input  wire error_sync_pkg::level_t                wb_level_i,
   input  wire logic                                  wb_nonsecure_i,
   output logic [31:0]                                wb_dat_o,
   output logic                                       wb_ack_o,
   output logic                                       wb_err_o,
   // Error sources from pipeline and memory system
   input  wire logic                                  err_valid,
   input  wire error_sync_pkg::err_report_t           err_report,
   input  wire logic                                  err_inflight,
   // Synchronization request from pipeline
   input  wire logic                                  sync_valid,
   input  wire error_sync_pkg::sync_req_t             sync_req,
   output logic                                       sync_done,
   // Towards exception entry logic
   output error_sync_pkg::take_t                      take_out,
   output logic                                       take_valid,
   output logic                                       phys_pending
);

   localparam logic [1:0] DRAIN_MAX = 2'(error_sync_pkg::DRAIN_CYCLES);

   error_sync_pkg::state_t state;
   error_sync_pkg::sync_req_t req;
   logic [1:0] drain_cnt;
   logic [31:0] control;
   logic [error_sync_pkg::SYND_W-1:0] vsyndrome;
   logic [error_sync_pkg::SYND_W-1:0] pend_synd;
   logic pend_uncont;
   logic defer_flag;
   logic [error_sync_pkg::SYND_W-1:0] defer_synd;
   logic vdefer_flag;
   logic [error_sync_pkg::SYND_W-1:0] vdefer_synd;

   // Decoded control bits
   logic hyp_en;
   logic hyp_async_abort_route_bit;
   logic hyp_trap_general_bit;
   logic virtual_error_pending_bit;
   logic [3:0] impl_bits;
   logic monitor_implicit_barrier_bit;
   assign hyp_en = control[error_sync_pkg::CTL_HYP_EN_BIT];
   assign hyp_async_abort_route_bit = control[error_sync_pkg::CTL_ROUTE_BIT];
   assign hyp_trap_general_bit = control[error_sync_pkg::CTL_TRAPG_BIT];
   assign virtual_error_pending_bit = control[error_sync_pkg::CTL_VPEND_BIT];
   assign impl_bits = control[error_sync_pkg::CTL_IMPL_BIT +: 4];
   assign monitor_implicit_barrier_bit = impl_bits[3]
      | (control[error_sync_pkg::CTL_DBLF_BIT] & control[error_sync_pkg::CTL_NMABT_BIT]);

   // Does the request apply a barrier at all
   logic barrier_active;
   always_comb begin
      case (sync_req.kind)
         error_sync_pkg::SYNC_BARRIER: barrier_active = 1'b1;
         error_sync_pkg::SYNC_RETURN: barrier_active = 1'b1;
         error_sync_pkg::SYNC_ENTRY: begin
            if (sync_req.level == error_sync_pkg::LVL_MONITOR) begin
               barrier_active = monitor_implicit_barrier_bit;
            end else begin
               barrier_active = (sync_req.level != error_sync_pkg::LVL_USER)
                  & impl_bits[sync_req.level];
            end
         end
         default: barrier_active = 1'b0;
      endcase
   end

   // Virtual error synchronized by explicit barrier at user or kernel level
   logic virt_sync;
   assign virt_sync = (req.kind == error_sync_pkg::SYNC_BARRIER)
      & (req.level == error_sync_pkg::LVL_USER || req.level == error_sync_pkg::LVL_KERNEL)
      & hyp_en & hyp_async_abort_route_bit & ~hyp_trap_general_bit;

   logic resolving;
   logic explicit_barrier;
   logic defer_phys;
   logic take_phys_now;
   logic defer_virt;
   logic take_virt_now;
   assign resolving = (state == error_sync_pkg::ST_RESOLVE);
   assign explicit_barrier = (req.kind == error_sync_pkg::SYNC_BARRIER);
   assign take_phys_now = resolving & phys_pending & ~req.phys_masked;
   // Masked uncontainable errors are left pending rather than deferred
   assign defer_phys = resolving & phys_pending & req.phys_masked & explicit_barrier
      & ~pend_uncont;
   assign take_virt_now = resolving & virt_sync & virtual_error_pending_bit
      & ~req.virt_masked & ~take_phys_now;
   assign defer_virt = resolving & virt_sync & virtual_error_pending_bit
      & req.virt_masked;

   // Sequencer
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         state <= error_sync_pkg::ST_IDLE;
         req <= '0;
         drain_cnt <= 2'h0;
      end else begin
         case (state)
            error_sync_pkg::ST_IDLE: begin
               if (sync_valid && barrier_active) begin
                  state <= error_sync_pkg::ST_DRAIN;
                  req <= sync_req;
                  drain_cnt <= 2'h0;
               end
            end
            error_sync_pkg::ST_DRAIN: begin
               // Wait until earlier errors have landed in the pending latch
               if (!err_inflight && drain_cnt >= DRAIN_MAX - 2'h1) begin
                  state <= error_sync_pkg::ST_RESOLVE;
               end
               if (drain_cnt != DRAIN_MAX) begin
                  drain_cnt <= drain_cnt + 2'h1;
               end
            end
            error_sync_pkg::ST_RESOLVE: state <= error_sync_pkg::ST_IDLE;
            default: state <= error_sync_pkg::ST_IDLE;
         endcase
      end
   end

   // Completion strobe; inactive requests complete at once
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         sync_done <= 1'b0;
      end else begin
         sync_done <= resolving
            | (state == error_sync_pkg::ST_IDLE && sync_valid && !barrier_active);
      end
   end

   // Physical pending latch; a new error in the resolve cycle wins over the clear
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         phys_pending <= 1'b0;
         pend_synd <= error_sync_pkg::SYND_RESET;
         pend_uncont <= 1'b0;
      end else begin
         if (err_valid && (err_report.unrecoverable || err_report.uncontainable)) begin
            phys_pending <= 1'b1;
            pend_synd <= err_report.syndrome;
            pend_uncont <= pend_uncont | err_report.uncontainable;
         end else if (take_phys_now || defer_phys) begin
            phys_pending <= 1'b0;
            pend_uncont <= 1'b0;
         end
      end
   end

   // Take report to exception entry logic
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         take_valid <= 1'b0;
         take_out <= '0;
      end else begin
         take_valid <= take_phys_now | take_virt_now;
         take_out.take_phys <= take_phys_now;
         take_out.take_virt <= take_virt_now;
         take_out.precise <= 1'b1;
         take_out.return_addr <= req.pc;
         if (take_phys_now) begin
            take_out.syndrome <= pend_synd;
            if (!pend_uncont) begin
               take_out.syndrome[error_sync_pkg::ETYPE_LSB +: 3] <=
                  error_sync_pkg::ETYPE_UNREC;
            end
            // Taken after entry completes, so flag the implicit source
            take_out.syndrome[error_sync_pkg::IMPL_IND_BIT] <=
               (req.kind == error_sync_pkg::SYNC_ENTRY);
         end else begin
            take_out.syndrome <= vsyndrome;
         end
      end
   end

   // Bus access decode
   logic wb_req;
   logic access_ok;
   logic route_virtual;
   assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
   assign access_ok = (wb_level_i != error_sync_pkg::LVL_USER);
   assign route_virtual = hyp_en & hyp_async_abort_route_bit & wb_nonsecure_i
      & (wb_level_i == error_sync_pkg::LVL_KERNEL);
   logic wr_def;
   logic wr_vdef;
   assign wr_def = wb_req & wb_we_i & access_ok & wb_sel_i[3] & ~route_virtual
      & (wb_adr_i == error_sync_pkg::OFS_DEFERRED);
   assign wr_vdef = wb_req & wb_we_i & access_ok & wb_sel_i[3]
      & ((wb_adr_i == error_sync_pkg::OFS_VDEFERRED)
      | (route_virtual & wb_adr_i == error_sync_pkg::OFS_DEFERRED));

   // Deferred registers; hardware deferral only from explicit barriers
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         defer_flag <= 1'b0;
         defer_synd <= error_sync_pkg::SYND_RESET;
      end else if (defer_phys) begin
         defer_flag <= 1'b1;
         defer_synd <= pend_synd;
         if (!pend_uncont) begin
            defer_synd[error_sync_pkg::ETYPE_LSB +: 3] <= error_sync_pkg::ETYPE_UNREC;
         end
      end else if (wr_def) begin
         defer_flag <= wb_dat_i[error_sync_pkg::DEFER_FLAG_BIT];
         defer_synd <= wb_dat_i[error_sync_pkg::SYND_W-1:0];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         vdefer_flag <= 1'b0;
         vdefer_synd <= error_sync_pkg::SYND_RESET;
      end else if (defer_virt) begin
         vdefer_flag <= 1'b1;
         vdefer_synd <= vsyndrome;
      end else if (wr_vdef) begin
         vdefer_flag <= wb_dat_i[error_sync_pkg::DEFER_FLAG_BIT];
         vdefer_synd <= wb_dat_i[error_sync_pkg::SYND_W-1:0];
      end
   end

   // Control and virtual syndrome source; barrier clear beats software set
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         control <= error_sync_pkg::CONTROL_RESET;
         vsyndrome <= error_sync_pkg::SYND_RESET;
      end else begin
         if (wb_req && wb_we_i && access_ok && wb_adr_i == error_sync_pkg::OFS_CONTROL) begin
            for (int b = 0; b < 4; b++) begin
               if (wb_sel_i[b]) begin
                  control[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
               end
            end
         end
         if (defer_virt || take_virt_now) begin
            control[error_sync_pkg::CTL_VPEND_BIT] <= 1'b0;
         end
         if (wb_req && wb_we_i && access_ok && wb_adr_i == error_sync_pkg::OFS_VSYNDROME) begin
            vsyndrome <= wb_dat_i[error_sync_pkg::SYND_W-1:0];
         end
      end
   end

   // Bus answer, one cycle after the request is seen
   logic [31:0] rd_data;
   logic addr_hit;
   always_comb begin
      rd_data = 32'h0000_0000;
      addr_hit = 1'b1;
      case (wb_adr_i)
         error_sync_pkg::OFS_DEFERRED: begin
            if (route_virtual) begin
               rd_data = {vdefer_flag, 6'h00, vdefer_synd};
            end else begin
               rd_data = {defer_flag, 6'h00, defer_synd};
            end
         end
         error_sync_pkg::OFS_VDEFERRED: rd_data = {vdefer_flag, 6'h00, vdefer_synd};
         error_sync_pkg::OFS_CONTROL: rd_data = control;
         error_sync_pkg::OFS_VSYNDROME: rd_data = {7'h00, vsyndrome};
         error_sync_pkg::OFS_STATUS: begin
            rd_data[error_sync_pkg::STS_PEND_BIT] = phys_pending;
            rd_data[error_sync_pkg::STS_UNCONT_BIT] = pend_uncont;
            rd_data[error_sync_pkg::STS_VPEND_BIT] = virtual_error_pending_bit;
            rd_data[error_sync_pkg::STS_BUSY_BIT] = (state != error_sync_pkg::ST_IDLE);
         end
         default: addr_hit = 1'b0;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         wb_ack_o <= 1'b0;
         wb_err_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= wb_req & addr_hit & access_ok;
         wb_err_o <= wb_req & ~(addr_hit & access_ok);
         wb_dat_o <= (wb_req && !wb_we_i && access_ok) ? rd_data : 32'h0000_0000;
      end
   end

   // Synchronous aborts and recovery interrupts have no port here at all

endmodule

`default_nettype wire

// *** error_sync_barrier_unit_bench.sv ***
// Testbench for the error synchronization barrier unit
`timescale 1ns/1ps
`default_nettype none

module error_sync_barrier_unit_bench;
   localparam logic [24:0] SYN = 25'h1550003;
   logic ref_clk = 1'b0;
   logic reset = 1'b1;
   logic wb_cyc_i = 1'b0;
   logic wb_stb_i = 1'b0;
   logic wb_we_i = 1'b0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [31:0] wb_dat_i = 32'h0000_0000;
   error_sync_pkg::level_t wb_level_i = error_sync_pkg::LVL_KERNEL;
   logic wb_nonsecure_i = 1'b0;
   logic sync_valid = 1'b0;
   error_sync_pkg::sync_req_t sync_req = '0;
   logic go = 1'b0;
   logic [3:0] go_len = 4'h0;
   error_sync_pkg::err_report_t go_rep = '0;
   logic [31:0] wb_dat_o;
   logic wb_ack_o, wb_err_o, err_valid, err_inflight, sync_done, take_valid, phys_pending;
   error_sync_pkg::err_report_t err_report;
   error_sync_pkg::take_t take_out, tk;
   logic [31:0] rdata;
   logic rerr, tv;
   int lat;
   int num_errors = 0;
   int compares = 0;

   error_sync_barrier_unit dut (.ref_clk, .reset, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
      .wb_sel_i(4'hF), .wb_dat_i, .wb_level_i, .wb_nonsecure_i, .wb_dat_o, .wb_ack_o,
      .wb_err_o, .err_valid, .err_report, .err_inflight, .sync_valid, .sync_req, .sync_done,
      .take_out, .take_valid, .phys_pending);
   error_source_model src (.ref_clk, .reset, .go, .go_len, .go_rep, .err_valid, .err_report,
      .err_inflight);

   always #25 ref_clk = ~ref_clk;

   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask

   localparam error_sync_pkg::level_t U = error_sync_pkg::LVL_USER;
   localparam error_sync_pkg::level_t K = error_sync_pkg::LVL_KERNEL;
   localparam error_sync_pkg::level_t H = error_sync_pkg::LVL_HYP;
   localparam error_sync_pkg::sync_kind_t BR = error_sync_pkg::SYNC_BARRIER;
   localparam error_sync_pkg::sync_kind_t EN = error_sync_pkg::SYNC_ENTRY;
   localparam logic [7:0] DEF = error_sync_pkg::OFS_DEFERRED;
   localparam logic [7:0] CTL = error_sync_pkg::OFS_CONTROL;
   localparam error_sync_pkg::err_report_t UNREC = '{1'b1, 1'b0, SYN};

   task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                      input error_sync_pkg::level_t lvl);
      @(posedge ref_clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_dat_i <= dat;
      wb_level_i <= lvl;
      // A missing answer is left to the watchdog
      do @(posedge ref_clk); while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1);
      rdata = wb_dat_o;
      rerr = wb_err_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask

   task automatic err_go(input error_sync_pkg::err_report_t r, input logic [3:0] len);
      @(posedge ref_clk);
      go <= 1'b1;
      go_rep <= r;
      go_len <= len;
      @(posedge ref_clk);
      go <= 1'b0;
   endtask

   task automatic pend(input error_sync_pkg::err_report_t r);
      err_go(r, 4'h1);
      repeat (3) @(posedge ref_clk);
   endtask

   task automatic bar(input error_sync_pkg::sync_kind_t k, input error_sync_pkg::level_t l,
                      input logic [31:0] pc, input logic pm, input logic vm);
      @(posedge ref_clk);
      sync_valid <= 1'b1;
      sync_req <= '{pc, k, l, 1'b1, pm, vm};
      @(posedge ref_clk);
      sync_valid <= 1'b0;
      // Edges counted after the one that takes the request
      lat = 0;
      while (sync_done !== 1'b1) begin
         @(posedge ref_clk);
         lat++;
      end
      tv = take_valid;
      tk = take_out;
   endtask

   task automatic wrap_up();
      $display("compares=%0d num_errors=%0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge ref_clk);
      num_errors++;
      wrap_up();
   end

   initial begin
      repeat (6) @(posedge ref_clk);
      reset <= 1'b0;
      bus(1'b0, CTL, 32'h0, K);
      chk("control reset", rdata, error_sync_pkg::CONTROL_RESET);
      bus(1'b0, CTL, 32'h0, U);
      chk("user refused", rerr, 1'b1);
      bus(1'b0, 8'h14, 32'h0, K);
      chk("unmapped refused", rerr, 1'b1);
      // Error still travelling while the barrier drains
      err_go(UNREC, 4'h4);
      bar(BR, K, 32'h0000_1000, 1'b0, 1'b0);
      chk("inflight taken", tv, 1'b1);
      chk("take phys", tk.take_phys, 1'b1);
      chk("take syndrome", tk.syndrome, SYN);
      chk("take precise", tk.precise, 1'b1);
      chk("pending after take", phys_pending, 1'b0);
      pend(UNREC);
      bar(BR, K, 32'h0000_2000, 1'b1, 1'b0);
      chk("masked not taken", tv, 1'b0);
      chk("masked cleared", phys_pending, 1'b0);
      bus(1'b0, DEF, 32'h0, K);
      chk("deferred record", rdata, 32'h8155_0003);
      bus(1'b1, DEF, 32'h0, K);
      bar(BR, K, 32'h0000_3000, 1'b1, 1'b0);
      pend(UNREC);
      chk("later error pends", phys_pending, 1'b1);
      bus(1'b0, DEF, 32'h0, K);
      chk("later not deferred", rdata, 32'h0000_0000);
      bus(1'b1, CTL, 32'h0000_0200, K);
      bar(EN, K, 32'h0000_4000, 1'b1, 1'b0);
      chk("entry masked", tv, 1'b0);
      chk("entry keeps pending", phys_pending, 1'b1);
      bus(1'b0, DEF, 32'h0, K);
      chk("implicit no record", rdata, 32'h0000_0000);
      bar(EN, K, 32'h0000_4400, 1'b0, 1'b0);
      chk("entry taken", tv, 1'b1);
      chk("implicit indicator", tk.syndrome[error_sync_pkg::IMPL_IND_BIT], 1'b1);
      pend(UNREC);
      bar(EN, H, 32'h0000_4800, 1'b0, 1'b0);
      chk("inactive quick", lat, 1);
      chk("inactive no take", tv, 1'b0);
      bus(1'b1, CTL, 32'h0000_0F00, K);
      bar(EN, U, 32'h0000_4C00, 1'b0, 1'b0);
      chk("user entry no take", tv, 1'b0);
      bar(error_sync_pkg::SYNC_RETURN, K, 32'h0000_5000, 1'b0, 1'b0);
      chk("return taken", tv, 1'b1);
      chk("return address", tk.return_addr, 32'h0000_5000);
      // Nonmaskable abort with the extension forces the monitor barrier on
      bus(1'b1, CTL, 32'h0000_0030, K);
      pend(UNREC);
      bar(EN, error_sync_pkg::LVL_MONITOR, 32'h0000_6000, 1'b0, 1'b0);
      chk("monitor forced", tv, 1'b1);
      pend('{1'b0, 1'b1, SYN});
      bar(BR, K, 32'h0000_6400, 1'b1, 1'b0);
      bus(1'b0, error_sync_pkg::OFS_STATUS, 32'h0, K);
      chk("uncontainable stays", rdata, 32'h0000_0003);
      bar(BR, K, 32'h0000_6800, 1'b0, 1'b0);
      bus(1'b1, error_sync_pkg::OFS_VSYNDROME, 32'h0000_0ABC, H);
      bus(1'b1, CTL, 32'h0000_000B, H);
      bar(BR, K, 32'h0000_7000, 1'b1, 1'b1);
      bus(1'b0, error_sync_pkg::OFS_VDEFERRED, 32'h0, H);
      chk("virtual record", rdata, 32'h8000_0ABC);
      bus(1'b0, CTL, 32'h0, H);
      chk("virtual pend cleared", rdata, 32'h0000_0003);
      wb_nonsecure_i <= 1'b1;
      bus(1'b0, DEF, 32'h0, K);
      chk("routed read", rdata, 32'h8000_0ABC);
      wb_nonsecure_i <= 1'b0;
      bus(1'b1, CTL, 32'h0000_000B, H);
      bar(BR, K, 32'h0000_7400, 1'b1, 1'b0);
      chk("virtual taken", tk.take_virt & tv, 1'b1);
      bus(1'b1, CTL, 32'h0000_000F, H);
      bar(BR, K, 32'h0000_7800, 1'b1, 1'b1);
      bus(1'b0, CTL, 32'h0, H);
      chk("trap general no sync", rdata, 32'h0000_000F);
      wrap_up();
   end
endmodule

`default_nettype wire

// *** error_sync_barrier_unit_chk.sv ***
// Port checker for the error synchronization barrier unit
`timescale 1ns/1ps
`default_nettype none

module error_sync_barrier_unit_chk (
   input wire logic                        ref_clk,
   input wire logic                        reset,
   input wire logic                        wb_cyc_i,
   input wire logic                        wb_stb_i,
   input wire error_sync_pkg::level_t      wb_level_i,
   input wire logic [31:0]                 wb_dat_o,
   input wire logic                        wb_ack_o,
   input wire logic                        wb_err_o,
   input wire logic                        err_valid,
   input wire error_sync_pkg::err_report_t err_report,
   input wire logic                        sync_valid,
   input wire error_sync_pkg::sync_req_t   sync_req,
   input wire logic                        sync_done,
   input wire error_sync_pkg::take_t       take_out,
   input wire logic                        take_valid,
   input wire logic                        phys_pending
);
   logic        busy;
   logic [31:0] held_pc;
   logic        accept;

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (reset);

   // Requests while busy are dropped by the unit, so only track accepted ones
   assign accept = sync_valid && (!busy || sync_done);
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         busy <= 1'b0;
      end else if (accept) begin
         busy <= 1'b1;
      end else if (sync_done) begin
         busy <= 1'b0;
      end
   end
   always_ff @(posedge ref_clk) begin
      if (accept) begin
         held_pc <= sync_req.pc;
      end
   end

   sequence s_bus_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
   endsequence
   sequence s_pend_drop;
      phys_pending ##1 !phys_pending;
   endsequence

   property p_bus_answer;
      s_bus_req |=> (wb_ack_o != wb_err_o);
   endproperty
   a_bus_answer: assert property (p_bus_answer) else $error("bus request not answered once");
   property p_user_refused;
      s_bus_req and (wb_level_i == error_sync_pkg::LVL_USER) |=> wb_err_o && !wb_ack_o;
   endproperty
   a_user_refused: assert property (p_user_refused) else $error("user access not refused");
   property p_dat_idle;
      !wb_ack_o |-> (wb_dat_o == 32'h0000_0000);
   endproperty
   a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");
   property p_err_pends;
      err_valid && (err_report.unrecoverable || err_report.uncontainable) |=> phys_pending;
   endproperty
   a_err_pends: assert property (p_err_pends) else $error("error did not pend");
   property p_done_bound;
      accept |-> ##[1:40] sync_done;
   endproperty
   a_done_bound: assert property (p_done_bound) else $error("barrier never completed");
   property p_take_at_done;
      take_valid |-> sync_done && busy;
   endproperty
   a_take_at_done: assert property (p_take_at_done) else $error("take outside completion");
   property p_return_addr;
      take_valid |-> (take_out.return_addr == held_pc);
   endproperty
   a_return_addr: assert property (p_return_addr) else $error("wrong return address");
   property p_take_unrec;
      take_valid && take_out.take_phys |->
         (take_out.syndrome[error_sync_pkg::ETYPE_LSB +: 3] == error_sync_pkg::ETYPE_UNREC);
   endproperty
   a_take_unrec: assert property (p_take_unrec) else $error("take not unrecoverable");
   property p_precise;
      take_valid |-> take_out.precise;
   endproperty
   a_precise: assert property (p_precise) else $error("take not precise");
   property p_pend_clear;
      s_pend_drop |-> sync_done;
   endproperty
   a_pend_clear: assert property (p_pend_clear) else $error("pending lost outside barrier");
endmodule

bind error_sync_barrier_unit error_sync_barrier_unit_chk chk (.ref_clk, .reset, .wb_cyc_i,
   .wb_stb_i, .wb_level_i, .wb_dat_o, .wb_ack_o, .wb_err_o, .err_valid, .err_report,
   .sync_valid, .sync_req, .sync_done, .take_out, .take_valid, .phys_pending);

`default_nettype wire

// *** error_sync_pkg.sv ***
// Package: types and constants for the error synchronization barrier unit
package error_sync_pkg;

   localparam int SYND_W = 25;
   localparam int ADDR_W = 32;

   // Wishbone register offsets (byte addresses)
   localparam logic [7:0] OFS_DEFERRED = 8'h00;
   localparam logic [7:0] OFS_VDEFERRED = 8'h04;
   localparam logic [7:0] OFS_CONTROL = 8'h08;
   localparam logic [7:0] OFS_VSYNDROME = 8'h0C;
   localparam logic [7:0] OFS_STATUS = 8'h10;

   // Field positions
   localparam int DEFER_FLAG_BIT = 31;
   localparam int CTL_HYP_EN_BIT = 0;
   localparam int CTL_ROUTE_BIT = 1;
   localparam int CTL_TRAPG_BIT = 2;
   localparam int CTL_VPEND_BIT = 3;
   localparam int CTL_NMABT_BIT = 4;
   localparam int CTL_DBLF_BIT = 5;
   localparam int CTL_IMPL_BIT = 8;
   localparam int STS_PEND_BIT = 0;
   localparam int STS_UNCONT_BIT = 1;
   localparam int STS_VPEND_BIT = 2;
   localparam int STS_BUSY_BIT = 3;

   // Reset values
   localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
   localparam logic [SYND_W-1:0] SYND_RESET = 25'h0000000;

   // Error type field encoding inside syndrome bits [12:10]
   localparam int ETYPE_LSB = 10;
   localparam logic [2:0] ETYPE_UNREC = 3'h0;
   localparam int IMPL_IND_BIT = 13;

   // Drain wait bound for in-flight error sources
   localparam int DRAIN_CYCLES = 2;

   typedef enum logic [1:0] {
      LVL_USER = 2'h0,
      LVL_KERNEL = 2'h1,
      LVL_HYP = 2'h2,
      LVL_MONITOR = 2'h3
   } level_t;

   typedef enum logic [1:0] {
      SYNC_BARRIER = 2'h0,
      SYNC_ENTRY = 2'h1,
      SYNC_RETURN = 2'h2
   } sync_kind_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_DRAIN = 2'b01,
      ST_RESOLVE = 2'b11
   } state_t;

   typedef struct packed {
      logic [ADDR_W-1:0] pc;
      sync_kind_t kind;
      level_t level;
      logic nonsecure;
      logic phys_masked;
      logic virt_masked;
   } sync_req_t;

   typedef struct packed {
      logic unrecoverable;
      logic uncontainable;
      logic [SYND_W-1:0] syndrome;
   } err_report_t;

   typedef struct packed {
      logic take_phys;
      logic take_virt;
      logic precise;
      logic [ADDR_W-1:0] return_addr;
      logic [SYND_W-1:0] syndrome;
   } take_t;

endpackage
